// ==== hdl/tcs_pkg.sv ====
// Shared constants for the transceiver control and status supervisor
package tcs_pkg;
   // ------------------------------------------------------------
   // Clock and timing figures
   // ------------------------------------------------------------
   localparam int unsigned CLK_KHZ       = 50000;
   localparam int unsigned T_PROP_NS     = 1000;  // In/out propagation
   localparam int unsigned T_REJECT_NS   = 4500;  // Glitch rejection
   localparam int unsigned T_RESET_NS    = 10000; // Fault reset hold
   localparam int unsigned T_TICK_US     = 500;   // Suppression tick
   localparam int unsigned T_APC_MS      = 200;
   localparam int unsigned T_INIT_MS     = 300;
   localparam int unsigned T_DATA_MS     = 400;
   localparam int unsigned T_WR_MS       = 13;
   // Least times round up, longest times round down
   localparam int unsigned REJECT_CYC =
      (T_REJECT_NS * (CLK_KHZ / 1000) + 999) / 1000;
   localparam int unsigned RESET_CYC =
      (T_RESET_NS * (CLK_KHZ / 1000) + 999) / 1000;
   localparam int unsigned TICK_CYC  = T_TICK_US * (CLK_KHZ / 1000);
   localparam int unsigned APC_CYC   = T_APC_MS * CLK_KHZ;
   localparam int unsigned INIT_CYC  = T_INIT_MS * CLK_KHZ;
   localparam int unsigned DATA_CYC  = T_DATA_MS * CLK_KHZ;
   localparam int unsigned WR_CYC    = T_WR_MS * CLK_KHZ;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_EVENT  = 8'h08;
   localparam logic [7:0] ADR_MASK   = 8'h0C;
   // Control fields
   localparam int unsigned CTRL_RATE_OUT = 0;
   localparam int unsigned CTRL_SOFT_OFF = 1;
   localparam int unsigned CTRL_SUPP_LSB = 8;
   localparam int unsigned SUPP_W        = 8;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   // Status fields
   localparam int unsigned ST_FAULT   = 0;
   localparam int unsigned ST_OFF_REQ = 1;
   localparam int unsigned ST_LOS     = 2;
   localparam int unsigned ST_RATE_IN = 3;
   localparam int unsigned ST_APC     = 4;
   localparam int unsigned ST_READY   = 5;
   localparam int unsigned ST_NV_BUSY = 6;
   localparam int unsigned ST_SHDN    = 7;
   localparam int unsigned ST_LASER   = 8;
   // Event fields, shared by the event and mask registers
   localparam int unsigned EV_W        = 5;
   localparam int unsigned EV_FAULT    = 0;
   localparam int unsigned EV_LOS_SET  = 1;
   localparam int unsigned EV_LOS_CLR  = 2;
   localparam int unsigned EV_NV_DONE  = 3;
   localparam int unsigned EV_UV       = 4;
   localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
   // Power sequencing states
   typedef enum logic [1:0] {
      PWR_INIT = 2'b00,
      PWR_RUN  = 2'b01,
      PWR_SHDN = 2'b10
   } tcs_pwr_type;
endpackage

// ==== hdl/tcs_supervisor.sv ====
// Transceiver control and status supervisor with Wishbone registers
`timescale 1ns/1ns
module tcs_supervisor
   import tcs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = tcs_pkg::TICK_CYC,
   parameter int unsigned APC_CYCLES  = tcs_pkg::APC_CYC,
   parameter int unsigned INIT_CYCLES = tcs_pkg::INIT_CYC,
   parameter int unsigned DATA_CYCLES = tcs_pkg::DATA_CYC,
   parameter int unsigned WR_CYCLES   = tcs_pkg::WR_CYC
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Pins from outside the clock domain
   input  wire logic        laser_off_request_i,
   input  wire logic        fault_cmp_i,
   input  wire logic        rx_los_cmp_i,
   input  wire logic        rate_sel_input_i,
   input  wire logic        undervoltage_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   // From the serial engine on this clock
   input  wire logic        nv_write_pending_i,
   // Outputs
   output logic             laser_drive_o,
   output logic             auto_power_loop_o,
   output logic             laser_fault_flag_o,
   output logic             receive_signal_lost_o,
   output logic             rate_sel_output_o,
   output logic             data_ready_o,
   output logic             serial_ack_en_o,
   output logic             nv_busy_o,
   output logic             shutdown_o,
   output logic             irq_o
);
   import tcs_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (TICK_CYCLES < 2 || APC_CYCLES < 5 || WR_CYCLES < 1)
      $error("tcs_supervisor: counts too small");
   if (INIT_CYCLES < APC_CYCLES || DATA_CYCLES < APC_CYCLES)
      $error("tcs_supervisor: init and data must follow loop enable");

   // Byte-lane merge for register writes
   function automatic logic [31:0] merge
   (
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            r[b*8 +: 8] = new_v[b*8 +: 8];
      return r;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [6:0] pins_s;
   logic       off_s;
   logic       flt_s;
   logic       los_s;
   logic       rate_s;
   logic       uv_s;
   logic       scl_s;
   logic       sda_s;

   tcs_sync3 #(.WIDTH(7)) u_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   ({sda_i, scl_i, undervoltage_i, rate_sel_input_i,
                 rx_los_cmp_i, fault_cmp_i, laser_off_request_i}),
      .level_o (pins_s)
   );
   assign {sda_s, scl_s, uv_s, rate_s, los_s, flt_s, off_s} = pins_s;

   // ------------------------------------------------------------
   // Registers and bus
   // ------------------------------------------------------------
   logic [31:0]     ctrl_q;
   logic [EV_W-1:0] event_q;
   logic [EV_W-1:0] mask_q;
   logic [EV_W-1:0] ev_set;
   logic [31:0]     status;
   logic            wr_stb;
   logic            fault_q;
   logic            los_q;
   logic            apc_q;
   logic            ready_q;
   logic            busy_q;
   logic            laser_q;
   tcs_pwr_type     pwr_q;

   // A request is served once; ack drops the cycle after it is given
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   // Live status view
   always_comb
   begin
      status             = '0;
      status[ST_FAULT]   = fault_q;
      status[ST_OFF_REQ] = off_s;
      status[ST_LOS]     = los_q;
      status[ST_RATE_IN] = rate_s;
      status[ST_APC]     = apc_q;
      status[ST_READY]   = ready_q;
      status[ST_NV_BUSY] = busy_q;
      status[ST_SHDN]    = (pwr_q == PWR_SHDN);
      status[ST_LASER]   = laser_q;
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= '0;
      else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
      begin
         unique case (wb_adr_i)
            ADR_CTRL:   wb_dat_o <= ctrl_q;
            ADR_STATUS: wb_dat_o <= status;
            ADR_EVENT:  wb_dat_o <= 32'(event_q);
            ADR_MASK:   wb_dat_o <= 32'(mask_q);
            default:    wb_dat_o <= '0;
         endcase
      end
   end

   // Control and mask registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= CTRL_RESET;
         mask_q <= MASK_RESET;
      end
      else if (wr_stb && wb_adr_i == ADR_CTRL)
         ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
      else if (wr_stb && wb_adr_i == ADR_MASK)
         mask_q <= EV_W'(merge(32'(mask_q), wb_dat_i, wb_sel_i));
   end

   // Sticky events: write one to clear, a new event wins over the clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         event_q <= '0;
      else if (wr_stb && wb_adr_i == ADR_EVENT && wb_sel_i[0])
         event_q <= (event_q & ~wb_dat_i[EV_W-1:0]) | ev_set;
      else
         event_q <= event_q | ev_set;
   end

   // Interrupt holds while an unmasked event stands
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(event_q & mask_q);
   end

   // ------------------------------------------------------------
   // Power-on sequencing and shutdown
   // ------------------------------------------------------------
   logic [31:0] por_cnt_q;
   logic        uv_d1_q;

   // Saturating count from reset release
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         por_cnt_q <= '0;
      else if (por_cnt_q < DATA_CYCLES)
         por_cnt_q <= por_cnt_q + 32'h0000_0001;
   end

   // Shutdown is final until the next power-on reset
   // Run starts four cycles early to cover the stages behind the loop flag
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pwr_q <= PWR_INIT;
      else
      begin
         unique case (pwr_q)
            PWR_INIT:
               if (uv_s)
                  pwr_q <= PWR_SHDN;
               else if (por_cnt_q >= APC_CYCLES - 4)
                  pwr_q <= PWR_RUN;
            PWR_RUN:
               if (uv_s)
                  pwr_q <= PWR_SHDN;
            PWR_SHDN:
               pwr_q <= PWR_SHDN;
            default:
               pwr_q <= PWR_SHDN;
         endcase
      end
   end

   // Loop enable, data ready and undervoltage delay flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         apc_q   <= 1'b0;
         ready_q <= 1'b0;
         uv_d1_q <= 1'b0;
      end
      else
      begin
         apc_q   <= (pwr_q == PWR_RUN) && !uv_s;
         ready_q <= (por_cnt_q >= DATA_CYCLES);
         uv_d1_q <= uv_s;
      end
   end

   // ------------------------------------------------------------
   // Laser enable and initialisation timer
   // ------------------------------------------------------------
   logic        tx_en;
   logic        tx_en_q;
   logic [31:0] init_cnt_q;
   logic        init_done;

   // Software and pin requests both switch the laser off
   assign tx_en = !off_s && !ctrl_q[CTRL_SOFT_OFF] && apc_q;

   // Restarts on every enable so the fault flag masks the ramp-up
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         init_cnt_q <= '0;
         tx_en_q    <= 1'b0;
      end
      else
      begin
         tx_en_q <= tx_en;
         if (tx_en && !tx_en_q)
            init_cnt_q <= '0;
         else if (init_cnt_q < INIT_CYCLES - APC_CYCLES)
            init_cnt_q <= init_cnt_q + 32'h0000_0001;
      end
   end
   assign init_done = (init_cnt_q >= INIT_CYCLES - APC_CYCLES);

   // ------------------------------------------------------------
   // Fault comparator filter, suppression timer and latch
   // ------------------------------------------------------------
   localparam int unsigned GW = $clog2(REJECT_CYC + 2);
   localparam int unsigned RW = $clog2(RESET_CYC + 1);
   logic [GW-1:0]     flt_run_q;
   logic [GW-1:0]     los_run_q;
   logic              flt_f_q;
   logic [31:0]       tick_cnt_q;
   logic              tick;
   logic [SUPP_W-1:0] supp_q;
   logic [RW-1:0]     hold_q;
   logic              flt_new;

   // A level must outlast the rejection window before it is believed
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flt_run_q <= '0;
         los_run_q <= '0;
         flt_f_q   <= 1'b0;
         los_q     <= 1'b0;
      end
      else
      begin
         if (flt_s == flt_f_q)
            flt_run_q <= '0;
         else if (flt_run_q == GW'(REJECT_CYC))
            flt_f_q <= flt_s;
         else
            flt_run_q <= flt_run_q + 1'b1;
         if (los_s == los_q)
            los_run_q <= '0;
         else if (los_run_q == GW'(REJECT_CYC))
            los_q <= los_s;
         else
            los_run_q <= los_run_q + 1'b1;
      end
   end

   // Free-running 0.5 ms tick
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tick_cnt_q <= '0;
      else if (tick)
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
   end
   assign tick = (tick_cnt_q == TICK_CYCLES - 1);

   // Suppression window loaded at each enable, counted down in ticks
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         supp_q <= '0;
      else if (tx_en && !tx_en_q)
         supp_q <= ctrl_q[CTRL_SUPP_LSB +: SUPP_W];
      else if (tick && supp_q != '0)
         supp_q <= supp_q - 1'b1;
   end

   // Time that the laser off request has been held
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hold_q <= '0;
      else if (!off_s)
         hold_q <= '0;
      else if (hold_q != RW'(RESET_CYC))
         hold_q <= hold_q + 1'b1;
   end

   // Fault needs the laser running; a new fault beats the reset
   assign flt_new = flt_f_q && laser_q && (supp_q == '0);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fault_q <= 1'b0;
      else if (flt_new)
         fault_q <= 1'b1;
      else if (hold_q == RW'(RESET_CYC))
         fault_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // Nonvolatile write busy window
   // ------------------------------------------------------------
   logic        scl_d_q;
   logic        sda_d_q;
   logic        stop_det;
   logic [31:0] wr_cnt_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_d_q <= 1'b0;
         sda_d_q <= 1'b0;
      end
      else
      begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end
   // Stop: data rises while clock stays high
   assign stop_det = scl_s && scl_d_q && sda_s && !sda_d_q;

   // Busy from the stop that ends a staged write until the cycle ends
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_q   <= 1'b0;
         wr_cnt_q <= '0;
      end
      else if (!busy_q)
      begin
         wr_cnt_q <= '0;
         if (stop_det && nv_write_pending_i)
            busy_q <= 1'b1;
      end
      else if (wr_cnt_q == WR_CYCLES - 1)
         busy_q <= 1'b0;
      else
         wr_cnt_q <= wr_cnt_q + 32'h0000_0001;
   end

   // ------------------------------------------------------------
   // Event sources
   // ------------------------------------------------------------
   logic los_d1_q;
   logic busy_d1_q;
   logic fault_d1_q;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         los_d1_q   <= 1'b0;
         busy_d1_q  <= 1'b0;
         fault_d1_q <= 1'b0;
      end
      else
      begin
         los_d1_q   <= los_q;
         busy_d1_q  <= busy_q;
         fault_d1_q <= fault_q;
      end
   end

   always_comb
   begin
      ev_set             = '0;
      ev_set[EV_FAULT]   = fault_q && !fault_d1_q;
      ev_set[EV_LOS_SET] = los_q && !los_d1_q;
      ev_set[EV_LOS_CLR] = !los_q && los_d1_q;
      ev_set[EV_NV_DONE] = !busy_q && busy_d1_q;
      ev_set[EV_UV]      = uv_s && !uv_d1_q;
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         laser_q               <= 1'b0;
         laser_drive_o         <= 1'b0;
         auto_power_loop_o     <= 1'b0;
         laser_fault_flag_o    <= 1'b1;
         receive_signal_lost_o <= 1'b0;
         rate_sel_output_o     <= 1'b0;
         data_ready_o          <= 1'b0;
         serial_ack_en_o       <= 1'b1;
         nv_busy_o             <= 1'b0;
         shutdown_o            <= 1'b0;
      end
      else
      begin
         laser_q               <= tx_en && !fault_q;
         laser_drive_o         <= tx_en && !fault_q;
         auto_power_loop_o     <= apc_q;
         laser_fault_flag_o    <= fault_q || !init_done;
         receive_signal_lost_o <= los_q;
         rate_sel_output_o     <= ctrl_q[CTRL_RATE_OUT];
         data_ready_o          <= ready_q;
         serial_ack_en_o       <= !busy_q;
         nv_busy_o             <= busy_q;
         shutdown_o            <= (pwr_q == PWR_SHDN);
      end
   end
endmodule

// ==== hdl/tcs_sync3.sv ====
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ns
module tcs_sync3
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // ------------------------------------------------------------
   // Stages; only stage two reads stage one
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Each bit moves only when stages two and three agree
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               level_o[g] <= 1'b0;
            else if (s2_q[g] == s3_q[g])
               level_o[g] <= s3_q[g];
         end
      end
   endgenerate
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the supervisor
`timescale 1ns/1ns
module tb;
   import tcs_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, off, flt, los, rin, uv, go;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rd, dat_o;
   logic        ack, drive, auto_power_loop, fflag, lost, rout, rdy, ack_en, busy;
   logic        shdn, irq, scl, sda, pend, done;
   int          err_total, n_compared, cyc_n, n;
   tcs_supervisor #(.TICK_CYCLES(10), .APC_CYCLES(50), .INIT_CYCLES(100),
      .DATA_CYCLES(150), .WR_CYCLES(40)) tcs_supervisor_i (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .laser_off_request_i(off), .fault_cmp_i(flt),
      .rx_los_cmp_i(los), .rate_sel_input_i(rin), .undervoltage_i(uv),
      .scl_i(scl), .sda_i(sda), .nv_write_pending_i(pend),
      .laser_drive_o(drive), .auto_power_loop_o(auto_power_loop),
      .laser_fault_flag_o(fflag), .receive_signal_lost_o(lost),
      .rate_sel_output_o(rout), .data_ready_o(rdy),
      .serial_ack_en_o(ack_en), .nv_busy_o(busy), .shutdown_o(shdn),
      .irq_o(irq));
   tcs_host_model tcs_host_model_i (.clk_i(clk_i), .go_i(go),
      .ack_en_i(ack_en), .scl_o(scl), .sda_o(sda), .pend_o(pend),
      .done_o(done));
   // Clock, and a ceiling on run length against hangs
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 40000)
      begin
         err_total++;
         stop_test();
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
         $display("Error t=%0t seen %h exp %h", $time, s, e);
      if (s !== e)
         err_total++;
   endtask
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One classic cycle; request held until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do
      begin
         @(posedge clk_i);
      end
      while (ack !== 1'b1);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   function logic sig(input int k);
      case (k)
         0: return drive;
         1: return fflag;
         2: return lost;
         3: return busy;
         4: return done;
         default: return shdn;
      endcase
   endfunction
   // Bounded wait for an output level; n counts the edges waited
   task wt(input int k, input logic v, input int lim);
      n = 0;
      while (sig(k) !== v && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task t_regs;
      wb(0, ADR_CTRL, 0);
      chk(rd, CTRL_RESET);
      wb(0, ADR_MASK, 0);
      chk(rd, {27'h0, MASK_RESET});
      wb(0, 8'h10, 0); // Unmapped reads zero
      chk(rd, 0);
      rin <= 1'b1;
      repeat (44) @(posedge clk_i);
      wb(0, ADR_STATUS, 0);
      chk(rd[ST_RATE_IN], 1);
      wb(1, ADR_CTRL, 32'h1);
      repeat (50) @(posedge clk_i);
      chk(rout, 1);
      $display("registers done");
   endtask
   task t_power;
      while (cyc_n < 170) @(posedge clk_i);
      chk(auto_power_loop, 1);
      chk(rdy, 1);
      chk({drive, fflag}, 2'b10);
      $display("power-up done");
   endtask
   // Short glitch ignored, real fault latched, reset by off hold
   task t_fault;
      wb(1, ADR_MASK, 32'h1F);
      flt <= 1'b1;
      repeat (200) @(posedge clk_i);
      flt <= 1'b0;
      repeat (300) @(posedge clk_i);
      chk(fflag, 0);
      flt <= 1'b1;
      wt(1, 1, 4750);
      chk({fflag, drive}, 2'b10);
      flt <= 1'b0;
      off <= 1'b1;
      repeat (510) @(posedge clk_i);
      off <= 1'b0;
      chk(irq, 1);
      repeat (10) @(posedge clk_i);
      wb(0, ADR_STATUS, 0);
      chk(rd[ST_FAULT], 0);
      wb(1, ADR_EVENT, 32'h1F);
      repeat (3) @(posedge clk_i);
      chk(irq, 0);
      $display("fault done");
   endtask
   task t_los;
      los <= 1'b1;
      wt(2, 1, 4750);
      chk(lost, 1);
      los <= 1'b0;
      wt(2, 0, 5000);
      chk(lost, 0);
      $display("loss done");
   endtask
   // Re-enable loads a 30-tick suppression window that hides a real fault
   task t_off;
      wt(0, 1, 20000);
      wb(1, ADR_CTRL, 32'h0000_1E01);
      off <= 1'b1;
      wt(0, 0, 500);
      chk(drive, 0);
      repeat (10) @(posedge clk_i);
      {off, flt} <= 2'b01;
      wt(0, 1, 15000);
      chk(drive, 1);
      repeat (250) @(posedge clk_i);
      chk(fflag, 0);
      wt(1, 1, 200);
      chk(fflag, 1);
      {off, flt} <= 2'b10;
      repeat (510) @(posedge clk_i);
      off <= 1'b0;
      $display("laser off done");
   endtask
   // Two writes back to back; the host waits out the busy time
   task t_nv;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      wt(4, 1, 500);
      wt(3, 1, 20);
      chk({busy, ack_en}, 2'b10);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      wt(3, 0, 60);
      chk(n <= 40, 1);
      wb(0, ADR_EVENT, 0);
      chk(rd[EV_NV_DONE], 1);
      wt(4, 1, 500);
      chk(done, 1);
      $display("nv write done");
   endtask
   task t_uv;
      uv <= 1'b1;
      wt(5, 1, 100);
      chk(shdn, 1);
      $display("undervoltage done");
   endtask
   initial
   begin
      {rst_i, cyc, stb, we, off, flt, los, rin, uv, go} = 10'h200;
      {adr, sel, wdat} = {8'h00, 4'hF, 32'h0};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_power();
      t_fault();
      t_los();
      t_off();
      t_nv();
      t_uv();
      stop_test();
   end
endmodule

// ==== verif/tcs_checker.sv ====
// Port-level checks for the supervisor
`timescale 1ns/1ns
module tcs_checker
#(
   parameter int unsigned APC_CYCLES = 50
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic laser_off_request_i,
   input wire logic fault_cmp_i,
   input wire logic rx_los_cmp_i,
   input wire logic laser_drive_o,
   input wire logic auto_power_loop_o,
   input wire logic laser_fault_flag_o,
   input wire logic receive_signal_lost_o,
   input wire logic serial_ack_en_o,
   input wire logic nv_busy_o,
   input wire logic shutdown_o
);
   logic [15:0] los_q;
   logic [15:0] flt_q;
   logic [15:0] up_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles the loss pin has stood high, saturating
   always_ff @(posedge clk_i)
      los_q <= (rst_i || !rx_los_cmp_i) ? 16'h0 : los_q + {15'h0, ~&los_q};
   // Fault pin high while laser driven; cleared once drive drops
   always_ff @(posedge clk_i)
      flt_q <= (rst_i || !fault_cmp_i || !laser_drive_o) ? 16'h0
               : flt_q + {15'h0, ~&flt_q};
   // Cycles since reset release
   always_ff @(posedge clk_i)
      up_q <= rst_i ? 16'h0 : up_q + {15'h0, ~&up_q};
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack not one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_off_cut: assert property (
      $rose(laser_off_request_i) ##1 laser_off_request_i [*8]
      |-> ##[0:490] !laser_drive_o) else $error("laser not cut");
   a_fault_flag: assert property (flt_q == 16'd4750
      |-> laser_fault_flag_o) else $error("fault flag late");
   a_los_assert: assert property (los_q == 16'd4750
      |-> receive_signal_lost_o) else $error("loss output late");
   a_glitch_reject: assert property (
      $rose(receive_signal_lost_o) |-> los_q > 16'd225)
      else $error("short pulse passed filter");
   a_busy_noack: assert property (nv_busy_o
      |-> !serial_ack_en_o) else $error("ack enabled while busy");
   a_shdn_sticky: assert property (shutdown_o |=> shutdown_o)
      else $error("shutdown dropped");
   a_apc_time: assert property (up_q == 16'(APC_CYCLES + 2)
      |-> auto_power_loop_o || shutdown_o) else $error("power loop late");
endmodule
bind tcs_supervisor tcs_checker #(.APC_CYCLES(APC_CYCLES)) tcs_checker_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .laser_off_request_i(laser_off_request_i),
   .fault_cmp_i(fault_cmp_i), .rx_los_cmp_i(rx_los_cmp_i),
   .laser_drive_o(laser_drive_o), .auto_power_loop_o(auto_power_loop_o),
   .laser_fault_flag_o(laser_fault_flag_o), .nv_busy_o(nv_busy_o),
   .receive_signal_lost_o(receive_signal_lost_o),
   .serial_ack_en_o(serial_ack_en_o), .shutdown_o(shutdown_o));

// ==== verif/tcs_host_model.sv ====
// Serial host model: short write frames ending in a stop condition
`timescale 1ns/1ns
module tcs_host_model
(
   input  wire logic clk_i,
   input  wire logic go_i,
   input  wire logic ack_en_i,
   output logic      scl_o,
   output logic      sda_o,
   output logic      pend_o,
   output logic      done_o
);
   // Lines idle high by pull-up; link clock still between frames
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      pend_o = 1'b0;
      done_o = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (go_i)
         begin
            // Retry until the device answers again
            while (!ack_en_i) @(posedge clk_i);
            sda_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            // Link clock of 160 ns within the frame
            repeat (8)
            begin
               scl_o <= 1'b0;
               repeat (4) @(posedge clk_i);
               scl_o <= 1'b1;
               repeat (4) @(posedge clk_i);
            end
            pend_o <= 1'b1;
            sda_o <= 1'b1; // Stop: data rises with clock high
            repeat (6) @(posedge clk_i);
            pend_o <= 1'b0;
            done_o <= 1'b1;
            @(posedge clk_i);
            done_o <= 1'b0;
         end
      end
   end
endmodule
